// file: inc/macs_pkg.sv
package macs_pkg;
  localparam int unsigned A_W = 25;
  localparam int unsigned B_W = 18;
  localparam int unsigned P_W = 48;
  localparam int unsigned LANE_W = 12;
  localparam int unsigned N_LANE = 4;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned CTRL_W = 12;
  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_PAT_LO = 6'h04;
  localparam logic [5:0] REG_PAT_HI = 6'h08;
  localparam logic [5:0] REG_MASK_LO = 6'h0c;
  localparam logic [5:0] REG_MASK_HI = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h14;
  localparam logic [5:0] REG_RES_LO = 6'h18;
  localparam logic [5:0] REG_RES_HI = 6'h1c;
  // Control field positions
  localparam int unsigned CTRL_PRE_EN = 0;
  localparam int unsigned CTRL_PRE_SUB = 1;
  localparam int unsigned CTRL_MREG = 2;
  localparam int unsigned CTRL_SIMD = 3;
  localparam int unsigned CTRL_LOGIC = 5;
  localparam int unsigned CTRL_FN = 6;
  localparam int unsigned CTRL_CNT = 10;
  localparam int unsigned CTRL_CASC = 11;
  // Status field positions
  localparam int unsigned STAT_MATCH = 0;
  localparam int unsigned STAT_MATCH_B = 1;
  localparam int unsigned STAT_RES_V = 2;
  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [47:0] PAT_RST = 48'h0000_0000_0000;
  localparam logic [47:0] MASK_RST = 48'h0000_0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MACS_SIMD_ONE, MACS_SIMD_TWO, MACS_SIMD_FOUR} macs_simd_t;
  typedef enum logic [3:0] {
    MACS_FN_AND, MACS_FN_OR, MACS_FN_XOR, MACS_FN_NAND, MACS_FN_NOR,
    MACS_FN_XNOR, MACS_FN_X_ANDN_Z, MACS_FN_NX_AND_Z, MACS_FN_X_ORN_Z, MACS_FN_NX_OR_Z
  } macs_fn_t;

  typedef struct packed {
    logic valid;
    logic bypass;
    logic sub;
    logic acc;
    logic [24:0] a;
    logic [17:0] b;
    logic [24:0] d;
    logic [47:0] c;
    logic [47:0] x;
  } macs_op_t;

  typedef struct packed {
    logic valid;
    logic sub;
    logic acc;
    logic [47:0] x;
    logic [47:0] c;
  } macs_stg_t;
endpackage

// file: rtl/macs_slice.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
module macs_slice
  import macs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire macs_op_t op_i,
  input wire logic [P_W-1:0] pcin_i,
  input wire logic pat_casc_i,
  output logic [P_W-1:0] res_o,
  output logic res_valid_o,
  output logic [P_W-1:0] pcout_o,
  output logic pat_match_o,
  output logic pat_match_b_o,
  output logic pat96_o
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [P_W-1:0] pat_q, mask_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  macs_stg_t stg_q;
  logic [P_W-1:0] res_q;
  logic res_v_q, pm_q, pmb_q, p96_q;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [P_W-1:0] lu(input logic [3:0] fn, input logic [P_W-1:0] x,
                                        input logic [P_W-1:0] z);
    case (macs_fn_t'(fn))
      MACS_FN_AND: return x & z;
      MACS_FN_OR: return x | z;
      MACS_FN_XOR: return x ^ z;
      MACS_FN_NAND: return ~(x & z);
      MACS_FN_NOR: return ~(x | z);
      MACS_FN_XNOR: return ~(x ^ z);
      MACS_FN_X_ANDN_Z: return x & ~z;
      MACS_FN_NX_AND_Z: return ~x & z;
      MACS_FN_X_ORN_Z: return x | ~z;
      MACS_FN_NX_OR_Z: return ~x | z;
      default: return '0;
    endcase
  endfunction

  // Control fields
  wire cfg_pre_en = ctrl_q[CTRL_PRE_EN];
  wire cfg_pre_sub = ctrl_q[CTRL_PRE_SUB];
  wire cfg_mreg = ctrl_q[CTRL_MREG];
  wire [1:0] cfg_simd = ctrl_q[CTRL_SIMD +: 2];
  wire cfg_logic = ctrl_q[CTRL_LOGIC];
  wire [3:0] cfg_fn = ctrl_q[CTRL_FN +: 4];
  wire cfg_cnt = ctrl_q[CTRL_CNT];
  wire cfg_casc = ctrl_q[CTRL_CASC];

  // Register bus: address and data may arrive in either order
  assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ce & ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire wr_go = ce & aw_have_q & w_have_q & ~bvalid_q;
  wire wr_hit = aw_addr_q[1:0] == 2'h0 && aw_addr_q <= REG_RES_HI;
  wire [31:0] ctrl_wr = wmerge({20'h0, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0] pat_lo_wr = wmerge(pat_q[31:0], w_data_q, w_strb_q);
  wire [31:0] pat_hi_wr = wmerge({16'h0, pat_q[47:32]}, w_data_q, w_strb_q);
  wire [31:0] mask_lo_wr = wmerge(mask_q[31:0], w_data_q, w_strb_q);
  wire [31:0] mask_hi_wr = wmerge({16'h0, mask_q[47:32]}, w_data_q, w_strb_q);
  wire rd_hit = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= REG_RES_HI;
  wire [31:0] stat_word = {29'h0, res_v_q, pmb_q, pm_q};
  wire [31:0] rd_word =
    s_axi_araddr == REG_CTRL ? {20'h0, ctrl_q} :
    s_axi_araddr == REG_PAT_LO ? pat_q[31:0] :
    s_axi_araddr == REG_PAT_HI ? {16'h0, pat_q[47:32]} :
    s_axi_araddr == REG_MASK_LO ? mask_q[31:0] :
    s_axi_araddr == REG_MASK_HI ? {16'h0, mask_q[47:32]} :
    s_axi_araddr == REG_STATUS ? stat_word :
    s_axi_araddr == REG_RES_LO ? res_q[31:0] :
    s_axi_araddr == REG_RES_HI ? {16'h0, res_q[47:32]} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      pat_q <= PAT_RST;
      mask_q <= MASK_RST;
    end else if (wr_go) begin
      if (aw_addr_q == REG_CTRL) ctrl_q <= ctrl_wr[CTRL_W-1:0];
      if (aw_addr_q == REG_PAT_LO) pat_q[31:0] <= pat_lo_wr;
      if (aw_addr_q == REG_PAT_HI) pat_q[47:32] <= pat_hi_wr[15:0];
      if (aw_addr_q == REG_MASK_LO) mask_q[31:0] <= mask_lo_wr;
      if (aw_addr_q == REG_MASK_HI) mask_q[47:32] <= mask_hi_wr[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Pre-adder wraps at 25 bits, as the multiplier port is only that wide
  wire [A_W-1:0] pre_sum = cfg_pre_sub ? op_i.d - op_i.a : op_i.d + op_i.a;
  wire [A_W-1:0] pre = cfg_pre_en ? pre_sum : op_i.a;
  logic signed [P_W-1:0] prod;
  assign prod = $signed(pre) * $signed(op_i.b);
  macs_stg_t s_in, s;
  assign s_in = '{valid: op_i.valid, sub: op_i.sub, acc: op_i.acc,
                  x: op_i.bypass ? op_i.x : prod, c: op_i.c};
  assign s = cfg_mreg ? stg_q : s_in;

  // Counter mode steps the held total by one every enabled clock
  wire alu_v = s.valid | cfg_cnt;
  wire alu_sub = cfg_cnt ? op_i.sub : s.sub;
  wire [P_W-1:0] alu_x = cfg_cnt ? 48'h0000_0000_0001 : s.x;
  wire [P_W-1:0] alu_z = cfg_casc ? pcin_i : (cfg_cnt | s.acc) ? res_q : s.c;

  logic [LANE_W:0] lane_sum [N_LANE];
  logic [N_LANE-1:0] cin;
  logic [P_W-1:0] sum;
  genvar g;
  for (g = 0; g < N_LANE; g++) begin : g_lane
    // Subtract as z + ~x + 1, with the +1 restarted at each lane edge where the SIMD mode splits the word
    wire [LANE_W-1:0] xl = alu_x[g*LANE_W +: LANE_W] ^ {LANE_W{alu_sub}};
    if (g == 0) begin : g_first
      assign cin[g] = alu_sub;
    end else begin : g_rest
      wire brk = cfg_simd == MACS_SIMD_FOUR ||
                 (cfg_simd == MACS_SIMD_TWO && g == 2);
      assign cin[g] = brk ? alu_sub : lane_sum[g-1][LANE_W];
    end
    assign lane_sum[g] = {1'b0, alu_z[g*LANE_W +: LANE_W]} + {1'b0, xl} + {12'h000, cin[g]};
    assign sum[g*LANE_W +: LANE_W] = lane_sum[g][LANE_W-1:0];
  end

  wire [P_W-1:0] res_d = !alu_v ? res_q : cfg_logic ? lu(cfg_fn, alu_x, alu_z) : sum;
  wire pm_d = ((res_d ^ pat_q) & ~mask_q) == '0;
  wire pmb_d = ((res_d ^ ~pat_q) & ~mask_q) == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stg_q <= '0;
      res_q <= '0;
      res_v_q <= 1'b0;
      pm_q <= 1'b0;
      pmb_q <= 1'b0;
      p96_q <= 1'b0;
    end else if (ce) begin
      stg_q <= s_in;
      res_q <= res_d;
      res_v_q <= alu_v;
      pm_q <= pm_d;
      pmb_q <= pmb_d;
      p96_q <= pm_d & pat_casc_i;
    end
  end

  assign res_o = res_q;
  assign res_valid_o = res_v_q;
  assign pcout_o = res_q;
  assign pat_match_o = pm_q;
  assign pat_match_b_o = pmb_q;
  assign pat96_o = p96_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire plain = ce & op_i.valid & ~cfg_mreg & ~cfg_cnt & ~cfg_casc & ~cfg_logic &
               cfg_simd == MACS_SIMD_ONE & ~op_i.sub;
  logic signed [P_W-1:0] chk_prod, chk_pre;
  wire [A_W-1:0] chk_pre_sum = op_i.d + op_i.a;
  assign chk_prod = $signed(op_i.a) * $signed(op_i.b);
  assign chk_pre = $signed(chk_pre_sum) * $signed(op_i.b);
  wire [23:0] chk_lo24 = alu_sub ? alu_z[23:0] - alu_x[23:0] : alu_z[23:0] + alu_x[23:0];
  wire [11:0] chk_hi12 = alu_sub ? alu_z[47:36] - alu_x[47:36] : alu_z[47:36] + alu_x[47:36];

  property p_mult;
    plain && !op_i.acc && !op_i.bypass && !cfg_pre_en |=> res_o == $past(op_i.c + chk_prod);
  endproperty
  a_mult: assert property (p_mult)
    else $error("product plus c wrong");
  property p_acc;
    plain && op_i.acc && op_i.bypass |=> res_o == $past(res_o + op_i.x);
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulate wrong");
  property p_bypass;
    plain && !op_i.acc && op_i.bypass |=> res_o == $past(op_i.c + op_i.x);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass sum wrong");
  property p_quad;
    ce && alu_v && !cfg_logic && cfg_simd == MACS_SIMD_FOUR |=> res_o[47:36] == $past(chk_hi12);
  endproperty
  a_quad: assert property (p_quad)
    else $error("top 12-bit lane wrong");
  property p_logic;
    ce && alu_v && cfg_logic && cfg_fn == MACS_FN_XOR |=> res_o == $past(alu_x ^ alu_z);
  endproperty
  a_logic: assert property (p_logic)
    else $error("logic xor wrong");
  property p_pre;
    plain && !op_i.acc && !op_i.bypass && cfg_pre_en && !cfg_pre_sub
      |=> res_o == $past(op_i.c + chk_pre);
  endproperty
  a_pre: assert property (p_pre)
    else $error("pre-adder path wrong");
  property p_pat;
    // Reset holds the flag low although a zero result matches a zero pattern
    ce && aresetn |=> pat_match_o == (((res_o ^ $past(pat_q)) & ~$past(mask_q)) == '0);
  endproperty
  a_pat: assert property (p_pat)
    else $error("pattern flag disagrees with result");
  property p_p96;
    ce |=> pat96_o == (pat_match_o && $past(pat_casc_i));
  endproperty
  a_p96: assert property (p_p96)
    else $error("wide match wrong");
  property p_cnt;
    ce && cfg_cnt && !cfg_casc && !cfg_logic && cfg_simd == MACS_SIMD_ONE && op_i.sub
      |=> res_o == $past(res_o) - 48'h0000_0000_0001;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("down count wrong");
  property p_pipe;
    ce && cfg_mreg && !cfg_cnt && op_i.valid ##1 ce && cfg_mreg |=> res_valid_o;
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipelined result not valid after two clocks");
  property p_lane;
    ce && alu_v && !cfg_logic && cfg_simd == MACS_SIMD_TWO |=> res_o[23:0] == $past(chk_lo24);
  endproperty
  a_lane: assert property (p_lane)
    else $error("low 24-bit lane leaked carry");
endmodule

// file: dv/macs_op_src.sv
`timescale 1ns/1ns
module macs_op_src
  import macs_pkg::*;
(
  input wire logic aclk,
  input wire logic go,
  input wire macs_op_t cmd,
  output macs_op_t op_i
);
  // Operands linger between ops, as plain user logic would leave them
  always_ff @(posedge aclk) begin
    if (go) op_i <= cmd;
    op_i.valid <= go;
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ns
module tb
  import macs_pkg::*;
  ;
  localparam logic [47:0] LX = 48'h0000_ffff_00ff;
  localparam logic [47:0] LZ = 48'h00ff_00ff_0f0f;
  logic aclk, aresetn, ce, go, pat_casc_i, res_valid_o, pat_match_o, pat_match_b_o, pat96_o;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [47:0] pcin_i, res_o, pcout_o, r;
  macs_op_t cmd, op_i;
  int n_mismatch, tests_run, cyc;

  macs_slice dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .op_i, .pcin_i, .pat_casc_i, .res_o, .res_valid_o,
    .pcout_o, .pat_match_o, .pat_match_b_o, .pat96_o);
  macs_op_src src (.aclk, .go, .cmd, .op_i);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Handshakes sampled at the falling edge, where combinational readies are settled
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] dt,
      input logic [1:0] er);
    logic ah, wh, rh, bh, vh, fin;
    logic [1:0] rs;
    logic [31:0] rd;
    fin = 1'b0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!fin) begin
      @(negedge aclk);
      {ah, wh, rh, bh, vh} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
        s_axi_rvalid};
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (rh) s_axi_arvalid <= 1'b0;
      if (wr && bh) s_axi_bready <= 1'b0;
      if (!wr && vh) s_axi_rready <= 1'b0;
      fin = wr ? bh : vh;
    end
    chk("resp", 48'(rs), 48'(er));
    if (!wr) chk("rdata", 48'(rd), 48'(dt));
  endtask

  function automatic macs_op_t mk(logic y, logic s, logic q, logic [24:0] a, logic [17:0] b,
      logic [24:0] d, logic [47:0] c, logic [47:0] x);
    return '{1'b1, y, s, q, a, b, d, c, x};
  endfunction

  function automatic logic [47:0] lf(int k);
    case (k)
      0: return LX & LZ;
      1: return LX | LZ;
      2: return LX ^ LZ;
      3: return ~(LX & LZ);
      4: return ~(LX | LZ);
      5: return ~(LX ^ LZ);
      6: return LX & ~LZ;
      7: return ~LX & LZ;
      8: return LX | ~LZ;
      9: return ~LX | LZ;
      default: return 48'h0;
    endcase
  endfunction

  task automatic send(input macs_op_t o);
    @(posedge aclk);
    cmd <= o;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  task automatic op(input macs_op_t o, input int lat, input logic [47:0] e);
    send(o);
    repeat (lat) @(posedge aclk);
    #1;
    chk("res", res_o, e);
    chk("pcout", pcout_o, e);
    chk("res_valid", 48'(res_valid_o), 48'h1);
  endtask

  task automatic t_regs();
    bus(1'b0, REG_CTRL, 32'h0, RESP_OKAY);
    bus(1'b1, REG_MASK_HI, 32'hffff_ffff, RESP_OKAY);
    bus(1'b0, REG_MASK_HI, 32'h0000_ffff, RESP_OKAY);
    bus(1'b1, REG_MASK_HI, 32'h0, RESP_OKAY);
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    bus(1'b1, REG_MASK_LO, 32'hffff_ffff, RESP_OKAY);
    bus(1'b0, REG_MASK_LO, 32'h0000_00ff, RESP_OKAY);
    @(posedge aclk);
    s_axi_wstrb <= 4'hf;
    bus(1'b1, REG_MASK_LO, 32'h0, RESP_OKAY);
    bus(1'b0, 6'h24, 32'h0, RESP_SLVERR);
    bus(1'b1, 6'h02, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_mul();
    op(mk(0, 0, 0, 25'h1fffffd, 18'h7, 0, 48'h64, 0), 1, 48'h4f);
    op(mk(0, 0, 0, 25'h1000000, 18'h20000, 0, 0, 0), 1, 48'h0200_0000_0000);
    op(mk(0, 0, 1, 25'h2, 18'h3, 0, 0, 0), 1, 48'h0200_0000_0006);
    op(mk(1, 1, 0, 25'h5, 18'h5, 0, 48'h2, 48'h8000_0000_0001), 1, 48'h8000_0000_0001);
    op(mk(1, 0, 1, 0, 0, 0, 0, 48'h1), 1, 48'h8000_0000_0002);
  endtask

  task automatic t_simd();
    bus(1'b1, REG_CTRL, 32'h10, RESP_OKAY);
    op(mk(1, 0, 0, 0, 0, 0, 48'h000f_ff80_0001, 48'h0010_0180_0fff), 1, 48'h0010_0000_0000);
    op(mk(1, 1, 0, 0, 0, 0, 0, 48'h1), 1, 48'h0fff);
    bus(1'b1, REG_CTRL, 32'h08, RESP_OKAY);
    op(mk(1, 0, 0, 0, 0, 0, 48'h00ff_ffff, 48'h0100_0001), 1, 48'h0100_0000);
  endtask

  task automatic t_logic();
    for (int k = 0; k < 11; k++) begin
      bus(1'b1, REG_CTRL, 32'(32'h20 | (k << 6)), RESP_OKAY);
      op(mk(1, 0, 0, 0, 0, 0, LZ, LX), 1, lf(k));
    end
  endtask

  task automatic t_pre();
    bus(1'b1, REG_CTRL, 32'h1, RESP_OKAY);
    op(mk(0, 0, 0, 25'h3, 18'h3fffe, 25'h4, 0, 0), 1, 48'hffff_ffff_fff2);
    bus(1'b1, REG_CTRL, 32'h3, RESP_OKAY);
    op(mk(0, 0, 0, 25'h3, 18'h3fffe, 25'h4, 0, 0), 1, 48'hffff_ffff_fffe);
  endtask

  task automatic t_pat();
    bus(1'b1, REG_CTRL, 32'h0, RESP_OKAY);
    bus(1'b1, REG_PAT_LO, 32'h1234_5678, RESP_OKAY);
    bus(1'b1, REG_PAT_HI, 32'h9abc, RESP_OKAY);
    bus(1'b1, REG_MASK_LO, 32'hff, RESP_OKAY);
    pat_casc_i <= 1'b1;
    op(mk(1, 0, 0, 0, 0, 0, 0, 48'h9abc_1234_5699), 1, 48'h9abc_1234_5699);
    chk("flags", 48'({pat_match_o, pat_match_b_o, pat96_o}), 48'h5);
    op(mk(1, 0, 0, 0, 0, 0, 0, 48'h6543_edcb_a900), 1, 48'h6543_edcb_a900);
    chk("flags", 48'({pat_match_o, pat_match_b_o, pat96_o}), 48'h2);
    @(posedge aclk);
    pat_casc_i <= 1'b0;
    op(mk(1, 0, 0, 0, 0, 0, 0, 48'h9abc_1234_5678), 1, 48'h9abc_1234_5678);
    chk("flags", 48'({pat_match_o, pat_match_b_o, pat96_o}), 48'h4);
    // Held result still matches; no op since, so the valid bit reads low
    bus(1'b0, REG_STATUS, 32'h0000_0001, RESP_OKAY);
    bus(1'b0, REG_RES_LO, 32'h1234_5678, RESP_OKAY);
    bus(1'b0, REG_RES_HI, 32'h0000_9abc, RESP_OKAY);
  endtask

  task automatic t_cnt();
    op(mk(1, 0, 0, 0, 0, 0, 48'h5, 0), 1, 48'h5);
    bus(1'b1, REG_CTRL, 32'h400, RESP_OKAY);
    @(negedge aclk);
    r = res_o;
    @(negedge aclk);
    chk("count_up", res_o, r + 48'h1);
    send(mk(1, 1, 0, 0, 0, 0, 0, 0));
    @(negedge aclk);
    r = res_o;
    @(negedge aclk);
    chk("count_down", res_o, r - 48'h1);
    @(posedge aclk);
    ce <= 1'b0;
    @(negedge aclk);
    r = res_o;
    repeat (2) @(negedge aclk);
    chk("ce_hold", res_o, r);
    @(posedge aclk);
    ce <= 1'b1;
  endtask

  task automatic t_pipe();
    bus(1'b1, REG_CTRL, 32'h4, RESP_OKAY);
    op(mk(0, 0, 0, 25'h2, 18'h3, 0, 48'h1, 0), 2, 48'h7);
    bus(1'b1, REG_CTRL, 32'h800, RESP_OKAY);
    op(mk(1, 0, 0, 0, 0, 0, 48'h5, 48'h1), 1, 48'h101);
  endtask

  initial begin
    {aresetn, go, pat_casc_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_wstrb, pcin_i} = {1'b1, 4'hf, 48'h100};
    cmd = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    $display("regs test ended");
    t_mul();
    $display("multiply test ended");
    t_simd();
    $display("lanes test ended");
    t_logic();
    $display("logic test ended");
    t_pre();
    $display("pre-adder test ended");
    t_pat();
    $display("pattern test ended");
    t_cnt();
    $display("counter test ended");
    t_pipe();
    $display("pipeline test ended");
    wrap_up();
  end
endmodule
